// [hw/mmseq_cfg.svh]
`ifndef MMSEQ_CFG_SVH
`define MMSEQ_CFG_SVH

// ********************************************************************
// register indexes and byte addresses
// ********************************************************************
`define MMSEQ_IDX_CHAN    6'h04
`define MMSEQ_IDX_SKIP    6'h05
`define MMSEQ_IDX_ALT     6'h06
`define MMSEQ_IDX_TMO     6'h0F
`define MMSEQ_IDX_STAT    6'h30
`define MMSEQ_ADDR_CHAN   {`MMSEQ_IDX_CHAN, 2'h0}
`define MMSEQ_ADDR_SKIP   {`MMSEQ_IDX_SKIP, 2'h0}
`define MMSEQ_ADDR_ALT    {`MMSEQ_IDX_ALT, 2'h0}
`define MMSEQ_ADDR_TMO    {`MMSEQ_IDX_TMO, 2'h0}
`define MMSEQ_ADDR_STAT   {`MMSEQ_IDX_STAT, 2'h0}

// ********************************************************************
// field positions and reset values
// ********************************************************************
`define MMSEQ_CHAN_AUX1   4
`define MMSEQ_CHAN_AUX2   5
`define MMSEQ_CHAN_GND    7
`define MMSEQ_CHAN_WMASK  8'hBF
`define MMSEQ_ALT_BIT     7
`define MMSEQ_TMO_DIS_BIT 7
`define MMSEQ_CHAN_RST    8'h0F
`define MMSEQ_SKIP_RST    8'h00
`define MMSEQ_SLOT_AUX1   4'h8
`define MMSEQ_SLOT_AUX2   4'h9
`define MMSEQ_SLOT_GND    4'hA

// ********************************************************************
// timing
// ********************************************************************
`define MMSEQ_CLK_NS      50
`define MMSEQ_TMO_NS      45000
`define MMSEQ_TMO_CYC     (`MMSEQ_TMO_NS / `MMSEQ_CLK_NS)

`endif

// [hw/mmseq_pkg.sv]
package mmseq_pkg;

    typedef enum logic [2:0] {
        MMSEQ_ST_HOLD = 3'b001,
        MMSEQ_ST_WAIT = 3'b010,
        MMSEQ_ST_RUN  = 3'b100
    } mmseq_state_e;

    typedef struct packed {
        logic       drive;
        logic       reversed;
        logic [3:0] slot;
    } mmseq_diff_s;

    typedef struct packed {
        logic [3:0] chan;
        logic       aux1;
        logic       aux2;
        logic       gnd;
        logic [3:0] skip_start;
        logic [3:0] skip_end;
        logic       alt;
    } mmseq_cfg_s;

endpackage

// [hw/mmseq_sync.sv]
`timescale 1ns/1ps
module mmseq_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                meta_r[i] <= 1'b0;
                q[i]      <= 1'b0;
            end else begin
                meta_r[i] <= d[i];
                q[i]      <= meta_r[i];
            end
        end
    end
endmodule // mmseq_sync

// [hw/mmseq_top.sv]
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "mmseq_cfg.svh"
module mmseq_top (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               slot_step_pulse,
    input  wire logic               enable_n_pin,
    input  wire logic               enable_float,
    input  wire logic               vcc_present,
    input  wire logic               skip_hold_pin,
    input  wire logic [3:0]         bus_voltage_input,
    output mmseq_pkg::mmseq_diff_s  diff_out,
    output logic                    bus_voltages_valid_oe
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [8:0] pins_s;
    logic       sel_s;
    logic       en_n_s;
    logic       float_s;
    logic       vcc_s;
    logic       hold_s;
    logic [3:0] bv_s;

    mmseq_sync #(.W(9)) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    ({slot_step_pulse, enable_n_pin, enable_float, vcc_present,
                skip_hold_pin, bus_voltage_input}),
        .q    (pins_s)
    );
    assign {sel_s, en_n_s, float_s, vcc_s, hold_s, bv_s} = pins_s;

    // ****************************************************************
    // apb register file
    // ****************************************************************
    logic [7:0]  chan_r, chan_nxt, skip_r, skip_nxt;
    logic        alt_r, alt_nxt, tmo_dis_r, tmo_dis_nxt;
    logic [31:0] prdata_nxt;
    logic        pready_nxt, pslverr_nxt, wr_en;
    logic [31:0] stat_w;

    always_comb begin
        chan_nxt    = chan_r;
        skip_nxt    = skip_r;
        alt_nxt     = alt_r;
        tmo_dis_nxt = tmo_dis_r;
        prdata_nxt  = prdata;
        pslverr_nxt = pslverr;
        pready_nxt  = psel & ~penable;
        wr_en       = psel & penable & pready & pwrite & ~pslverr;
        if (psel & ~penable) begin
            pslverr_nxt = 1'b0;
            if (paddr == `MMSEQ_ADDR_CHAN) begin
                prdata_nxt = {24'h000000, chan_r};
            end else if (paddr == `MMSEQ_ADDR_SKIP) begin
                prdata_nxt = {24'h000000, skip_r};
            end else if (paddr == `MMSEQ_ADDR_ALT) begin
                prdata_nxt = {24'h000000, alt_r, 7'h00};
            end else if (paddr == `MMSEQ_ADDR_TMO) begin
                prdata_nxt = {24'h000000, tmo_dis_r, 7'h00};
            end else if (paddr == `MMSEQ_ADDR_STAT) begin
                prdata_nxt = pwrite ? 32'h00000000 : stat_w;
                pslverr_nxt = pwrite;
            end else begin
                prdata_nxt  = 32'h00000000;
                pslverr_nxt = 1'b1;
            end
        end
        if (wr_en) begin
            if (paddr == `MMSEQ_ADDR_CHAN) begin
                chan_nxt = pwdata[7:0] & `MMSEQ_CHAN_WMASK;
            end else if (paddr == `MMSEQ_ADDR_SKIP) begin
                skip_nxt = pwdata[7:0];
            end else if (paddr == `MMSEQ_ADDR_ALT) begin
                alt_nxt = pwdata[`MMSEQ_ALT_BIT];
            end else if (paddr == `MMSEQ_ADDR_TMO) begin
                tmo_dis_nxt = pwdata[`MMSEQ_TMO_DIS_BIT];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chan_r    <= `MMSEQ_CHAN_RST;
            skip_r    <= `MMSEQ_SKIP_RST;
            alt_r     <= 1'b0;
            tmo_dis_r <= 1'b0;
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else begin
            chan_r    <= chan_nxt;
            skip_r    <= skip_nxt;
            alt_r     <= alt_nxt;
            tmo_dis_r <= tmo_dis_nxt;
            prdata    <= prdata_nxt;
            pready    <= pready_nxt;
            pslverr   <= pslverr_nxt;
        end
    end

    // ****************************************************************
    // slot sequencer
    // ****************************************************************
    function automatic logic [10:0] slot_mask(input mmseq_pkg::mmseq_cfg_s c);
        slot_mask = {c.gnd, c.aux2, c.aux1, {2{c.chan[3]}}, {2{c.chan[2]}},
                     {2{c.chan[1]}}, {2{c.chan[0]}}};
    endfunction

    function automatic logic [3:0] slot_count(input logic [10:0] m);
        slot_count = 4'h0;
        for (int i = 0; i < 11; i++) begin
            slot_count = slot_count + {3'h0, m[i]};
        end
    endfunction

    // nth enabled slot, lowest code first
    function automatic logic [3:0] slot_pick(input logic [10:0] m, input logic [5:0] n);
        logic [5:0] k;
        k = 6'h00;
        slot_pick = 4'h0;
        for (int i = 0; i < 11; i++) begin
            if (m[i]) begin
                if (k == n) begin
                    slot_pick = 4'(i);
                end
                k = k + 6'h01;
            end
        end
    endfunction

    mmseq_pkg::mmseq_state_e st_r, st_nxt;
    mmseq_pkg::mmseq_cfg_s   cfg_r, cfg_nxt, cfg_live;
    mmseq_pkg::mmseq_diff_s  diff_nxt;
    logic [5:0] pos_r, pos_nxt, len_cur, ss_n, n_nxt;
    logic [9:0] lvl_cnt_r, lvl_cnt_nxt;
    logic       pol_r, pol_nxt, sel_d_r, func_prev_r;
    logic       func, standby, step, chg, tmo, ok_all, valid_nxt;

    assign cfg_live = '{chan: chan_r[3:0], aux1: chan_r[`MMSEQ_CHAN_AUX1],
                        aux2: chan_r[`MMSEQ_CHAN_AUX2], gnd: chan_r[`MMSEQ_CHAN_GND],
                        skip_start: skip_r[7:4], skip_end: skip_r[3:0],
                        alt: alt_r};
    assign func    = ~float_s & ~en_n_s;
    assign standby = ~float_s & en_n_s;
    assign step    = sel_s & ~sel_d_r;
    assign chg     = sel_s ^ sel_d_r;
    assign len_cur = 6'(cfg_r.skip_start) + 6'(slot_count(slot_mask(cfg_r)))
                   + 6'(cfg_r.skip_end);
    assign tmo     = (st_r == mmseq_pkg::MMSEQ_ST_RUN) & ~tmo_dis_r & ~chg
                   & (lvl_cnt_r == 10'(`MMSEQ_TMO_CYC - 1));
    assign stat_w  = {18'h00000, valid_nxt, st_r, 1'b0, diff_out.drive, pol_r, 1'b0,
                      pos_r};

    always_comb begin
        st_nxt      = st_r;
        pos_nxt     = pos_r;
        pol_nxt     = pol_r;
        cfg_nxt     = cfg_r;
        lvl_cnt_nxt = (chg || st_r != mmseq_pkg::MMSEQ_ST_RUN) ? 10'h000
                    : lvl_cnt_r + {9'h000, lvl_cnt_r != 10'h3FF};
        if (!func) begin
            st_nxt  = mmseq_pkg::MMSEQ_ST_HOLD;
            pos_nxt = 6'h00;
            pol_nxt = 1'b0;
        end else if (!func_prev_r || tmo) begin
            st_nxt  = mmseq_pkg::MMSEQ_ST_WAIT;
            pos_nxt = 6'h00;
            pol_nxt = 1'b0;
        end else if (step) begin
            case (st_r)
                mmseq_pkg::MMSEQ_ST_WAIT: begin
                    st_nxt  = mmseq_pkg::MMSEQ_ST_RUN;
                    pos_nxt = 6'h00;
                    cfg_nxt = cfg_live;
                end
                mmseq_pkg::MMSEQ_ST_RUN: begin
                    if (pos_r + 6'h01 >= len_cur) begin
                        pos_nxt = 6'h00;
                        pol_nxt = cfg_r.alt & ~pol_r;
                        cfg_nxt = cfg_live;
                    end else begin
                        pos_nxt = pos_r + 6'h01;
                    end
                end
                default: begin
                    st_nxt = st_r;
                end
            endcase
        end
        // own slots sit between the start and end idle windows
        ss_n  = 6'(cfg_nxt.skip_start);
        n_nxt = 6'(slot_count(slot_mask(cfg_nxt)));
        diff_nxt.drive    = (st_nxt == mmseq_pkg::MMSEQ_ST_RUN) && (pos_nxt >= ss_n)
                          && (pos_nxt < ss_n + n_nxt);
        diff_nxt.reversed = pol_nxt;
        diff_nxt.slot     = slot_pick(slot_mask(cfg_nxt), pos_nxt - ss_n);
        ok_all    = &(bv_s | ~chan_r[3:0]);
        valid_nxt = hold_s & (~vcc_s | standby | ~ok_all);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r                  <= mmseq_pkg::MMSEQ_ST_HOLD;
            pos_r                 <= 6'h00;
            pol_r                 <= 1'b0;
            cfg_r                 <= '0;
            lvl_cnt_r             <= 10'h000;
            sel_d_r               <= 1'b0;
            func_prev_r           <= 1'b0;
            diff_out              <= '0;
            bus_voltages_valid_oe <= 1'b0;
        end else begin
            st_r                  <= st_nxt;
            pos_r                 <= pos_nxt;
            pol_r                 <= pol_nxt;
            cfg_r                 <= cfg_nxt;
            lvl_cnt_r             <= lvl_cnt_nxt;
            sel_d_r               <= sel_s;
            func_prev_r           <= func;
            diff_out              <= diff_nxt;
            bus_voltages_valid_oe <= valid_nxt;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic run_step;
    assign run_step = func && func_prev_r && !tmo && step && st_r == mmseq_pkg::MMSEQ_ST_RUN;

    chk_slot_enabled: assert property (
        diff_out.drive |-> ((slot_mask(cfg_r) >> diff_out.slot) & 11'h001) != 11'h000)
        else $error("disabled slot driven");
    chk_prestart_hiz: assert property (
        st_r == mmseq_pkg::MMSEQ_ST_WAIT |-> !diff_out.drive) else $error("drive before step");
    chk_hold_hiz: assert property (
        !func ##1 1 |-> st_r == mmseq_pkg::MMSEQ_ST_HOLD && !diff_out.drive)
        else $error("not held");
    chk_skip_window: assert property (
        st_r == mmseq_pkg::MMSEQ_ST_RUN && pos_r < 6'(cfg_r.skip_start) |-> !diff_out.drive)
        else $error("drive in start skip");
    chk_step_adv: assert property (
        run_step && pos_r + 6'h01 < len_cur |=> pos_r == 6'($past(pos_r) + 6'h01))
        else $error("no advance");
    chk_wrap_pol: assert property (
        run_step && pos_r + 6'h01 >= len_cur |=> pos_r == 6'h00
        && pol_r == ($past(cfg_r.alt) && !$past(pol_r))) else $error("bad wrap");
    chk_tmo_restart: assert property (
        func && func_prev_r && tmo |=> st_r == mmseq_pkg::MMSEQ_ST_WAIT && !pol_r)
        else $error("no timeout restart");
    chk_en_restart: assert property (
        func && !func_prev_r |=> st_r == mmseq_pkg::MMSEQ_ST_WAIT && !diff_out.drive)
        else $error("no enable restart");
    chk_valid_rel: assert property (
        !hold_s |=> !bus_voltages_valid_oe) else $error("valid not released");
    chk_valid_low: assert property (
        hold_s && (!vcc_s || standby) |=> bus_voltages_valid_oe) else $error("valid not low");
    chk_valid_mask: assert property (
        hold_s && vcc_s && !standby && (bv_s | ~chan_r[3:0]) == 4'hF
        |=> !bus_voltages_valid_oe) else $error("disabled channel counted");

    cov_wrap_rev: cover property (run_step && pos_r + 6'h01 >= len_cur && cfg_r.alt);
    cov_timeout: cover property (tmo && func && func_prev_r);
    cov_reversed: cover property (diff_out.drive && diff_out.reversed);
    cov_valid: cover property (hold_s && vcc_s ##1 !bus_voltages_valid_oe);
endmodule // mmseq_top

// [dv/mmseq_host.sv]
`timescale 1ns/1ps
module mmseq_host (
    input  wire mmseq_pkg::mmseq_diff_s diff_out,
    input  wire logic                   mclk,
    output logic                        slot_step_pulse
);
    // ********************************************************************
    // select pulse driver and adc sampler
    // ********************************************************************
    // line parked low between frames, so no stray edge reaches the device
    initial slot_step_pulse = 1'b0;

    // one full select cycle per call; the host must walk every slot itself
    task automatic step(output mmseq_pkg::mmseq_diff_s seen);
        @(posedge mclk);
        slot_step_pulse <= 1'b1;
        repeat (4) @(posedge mclk);
        slot_step_pulse <= 1'b0;
        // sample late: answer lands three edges after the rise
        repeat (4) @(posedge mclk);
        seen = diff_out;
    endtask
endmodule // mmseq_host

// [dv/monitor_mux_sequencer_tb.sv]
`timescale 1ns/1ps
module monitor_mux_sequencer_tb;
    logic                   mclk = 1'b0;
    logic                   rst = 1'b1;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   slot_step_pulse;
    logic                   enable_n_pin = 1'b0;
    logic                   enable_float = 1'b0;
    logic                   vcc_present = 1'b1;
    logic                   skip_hold_pin = 1'b0;
    logic [3:0]             bus_voltage_input = 4'h0;
    mmseq_pkg::mmseq_diff_s diff_out;
    logic                   bus_voltages_valid_oe;
    int                     n_mismatch = 0;
    int                     checks_done = 0;
    logic [8:0]             vt [7] = '{9'h12A, 9'h129, 9'h100, 9'h02B, 9'h1AB, 9'h1EA, 9'h1E3};

    always #25 mclk = ~mclk;

    mmseq_top mmseq_top_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slot_step_pulse(slot_step_pulse), .enable_n_pin(enable_n_pin),
        .enable_float(enable_float), .vcc_present(vcc_present), .skip_hold_pin(skip_hold_pin),
        .bus_voltage_input(bus_voltage_input), .diff_out(diff_out),
        .bus_voltages_valid_oe(bus_voltages_valid_oe));

    mmseq_host mmseq_host_inst (.diff_out(diff_out), .mclk(mclk),
        .slot_step_pulse(slot_step_pulse));

    // ********************************************************************
    // checking and bus tasks
    // ********************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        // no local limit: only the watchdog may end a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk(e, xe);
    endtask

    // steps n positions of a pass (0 = whole pass); gap = index idled 950 cycles before
    task automatic run_pass(input logic [7:0] ch, input logic [7:0] sk, input logic rv,
                            input int n, input int gap);
        logic [3:0]             slots [$];
        mmseq_pkg::mmseq_diff_s s;
        int                     i;
        repeat (sk[7:4]) slots.push_back(4'hF);
        for (i = 0; i < 4; i++) begin
            if (ch[i]) begin
                slots.push_back(4'(2 * i));
                slots.push_back(4'(2 * i + 1));
            end
        end
        if (ch[4]) slots.push_back(4'h8);
        if (ch[5]) slots.push_back(4'h9);
        if (ch[7]) slots.push_back(4'hA);
        repeat (sk[3:0]) slots.push_back(4'hF);
        if (n == 0) n = slots.size();
        for (i = 0; i < n; i++) begin
            if (i == gap) repeat (950) @(posedge mclk);
            mmseq_host_inst.step(s);
            if (slots[i] == 4'hF) chk(s.drive, 1'b0);
            else chk(s, {1'b1, rv, slots[i]});
        end
    endtask

    // ********************************************************************
    // tests
    // ********************************************************************
    initial begin
        logic [31:0]            r;
        logic                   e;
        mmseq_pkg::mmseq_diff_s s;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(diff_out.drive, 1'b0);
        rd_chk(8'h10, 32'h0F, 1'b0);
        rd_chk(8'h14, 32'h00, 1'b0);
        rd_chk(8'h18, 32'h00, 1'b0);
        rd_chk(8'h3C, 32'h00, 1'b0);
        rd_chk(8'h20, 32'h00, 1'b1);
        apb(1'b1, 8'hC0, 32'hFF, r, e);
        chk(e, 1'b1);
        wr(8'h10, 32'hFF);
        rd_chk(8'h10, 32'hBF, 1'b0);
        wr(8'h14, 32'h0B);
        wr(8'h18, 32'h80);
        run_pass(8'hBF, 8'h0B, 1'b0, 0, -1);
        run_pass(8'hBF, 8'h0B, 1'b1, 0, -1);
        run_pass(8'hBF, 8'h0B, 1'b0, 5, -1);
        enable_n_pin <= 1'b1;
        repeat (6) @(posedge mclk);
        mmseq_host_inst.step(s);
        chk(s.drive, 1'b0);
        rd_chk(8'hC0, 32'h00000400, 1'b0);
        enable_n_pin <= 1'b0;
        enable_float <= 1'b1;
        repeat (6) @(posedge mclk);
        mmseq_host_inst.step(s);
        chk(s.drive, 1'b0);
        enable_float <= 1'b0;
        repeat (6) @(posedge mclk);
        wr(8'h14, 32'hB0);
        wr(8'h18, 32'h00);
        run_pass(8'hBF, 8'hB0, 1'b0, 0, -1);
        wr(8'h10, 32'h05);
        wr(8'h14, 32'h00);
        run_pass(8'h05, 8'h00, 1'b0, 0, -1);
        run_pass(8'h05, 8'h00, 1'b0, 0, -1);
        run_pass(8'h05, 8'h00, 1'b0, 2, -1);
        repeat (950) @(posedge mclk);
        run_pass(8'h05, 8'h00, 1'b0, 0, -1);
        wr(8'h3C, 32'h80);
        run_pass(8'h05, 8'h00, 1'b0, 0, 2);
        foreach (vt[k]) begin
            {vcc_present, enable_n_pin, enable_float, skip_hold_pin, bus_voltage_input}
                <= vt[k][8:1];
            repeat (6) @(posedge mclk);
            chk(bus_voltages_valid_oe, vt[k][0]);
        end
        finish_test();
    end

    // watchdog: the full sequence needs about 2850 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end
endmodule // monitor_mux_sequencer_tb
